// [core/sslpm_top.sv]
// Behaviour
// RULE1: Low side fast-wake when supervisor or monitor is off or full perf.
// RULE2: High side at risk when a normal unit turns off in deep sleep.
// RULE3: Software waits for both settle flags zero before deep sleep.
// RULE4: Software may clear low supervisor full perf to pick slow wake-up.
// RULE5: Slow wake-up selected stretches deep-sleep wake time to 150 us.
// RULE6: Software may keep high units manual and on while asleep.
// RULE7: Hazard check reads 1 when configuration is affected, else 0.
// RULE8: Hazard is 0 unless the low side fast-wake condition holds.
// RULE9: High supervisor counts: enabled, not full perf, no keep or auto.
// RULE10: High monitor counts: enabled, not full perf, auto control set.
// RULE11: Software adds a 150 us delay when fast interrupt service matters.
// RULE12: Low auto: deep sleep normal only with enable, keep, full perf.
// RULE13: Low manual: deep sleep keeps active state with keep, else off.
// RULE14: Awake: off if disabled, full perf if bit set, else normal.
// RULE15: Monitors and high supervisor share the same state mapping.
// RULE16: Interrupt within 1 us of deep entry may fail to wake.
`timescale 1ns/1ns
`include "sslpm_consts.svh"
module sslpm_top
    import sslpm_pkg::*;
#(
    parameter logic [15:0] SETTLE_SLOW_CYCLES = 16'(`SSLPM_SLOW_CYC),
    parameter logic [15:0] WAKE_SLOW_CYCLES = 16'(`SSLPM_SLOW_CYC)
)
(
    input logic CORE_CLK,
    input logic SYS_RST,
    input logic HSEL,
    input logic [31:0] HADDR,
    input logic [1:0] HTRANS,
    input logic HWRITE,
    input logic [2:0] HSIZE,
    input logic [31:0] HWDATA,
    input logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input logic SLEEP_REQ,
    input sslpm_pkg::sslpm_level_t SLEEP_LEVEL,
    input logic WAKE_IRQ,
    output sslpm_pkg::sslpm_mode_t POWER_MODE,
    output logic SLEEP_ACK,
    output logic WAKE_DONE,
    output sslpm_pkg::sslpm_side_t LOW_STATE,
    output sslpm_pkg::sslpm_side_t HIGH_STATE,
    output logic CONFIG_HAZARD,
    output logic LOW_SETTLE,
    output logic HIGH_SETTLE,
    output logic WAKE_RISK
);

    // --------
    // Timing counts
    // --------
    localparam logic [15:0] SETTLE_FAST_CYC = 16'(`SSLPM_SETTLE_FAST_CYC);
    localparam logic [15:0] HAZARD_WIN_CYC = 16'(`SSLPM_HAZARD_WIN_CYC);
    localparam logic [15:0] WAKE_FAST_CYC = 16'(`SSLPM_WAKE_FAST_CYC);

    // --------
    // Declarations
    // --------
    sslpm_top_state_t r;
    sslpm_top_state_t next_r;
    sslpm_side_t low_map;
    sslpm_side_t high_map;
    sslpm_ctl_t wr_ctl;
    logic deep;
    logic addr_take;
    logic wr_low;
    logic wr_high;
    logic wr_status;
    logic low_busy;
    logic high_busy;
    logic settling;
    logic haz_busy;
    logic wake_start;
    logic wake_fire;
    logic deep_enter;
    logic [15:0] low_load;
    logic [15:0] high_load;
    logic [15:0] wake_load;
    logic low_fast;
    logic high_sup_risk;
    logic high_mon_risk;
    logic risk_hit;
    logic [31:0] status_word;

    function automatic logic sslpm_hit(
        input logic [7:0] addr,
        input logic [7:0] ofs
    );
        return addr == ofs;
    endfunction

    // --------
    // Bus decode
    // --------
    // Only whole-word transfers are decoded; other sizes are
    // answered OKAY and otherwise ignored.
    assign addr_take = HSEL && HREADY && HTRANS[1] &&
        (HSIZE == `SSLPM_HSIZE_WORD);
    assign wr_low = r.dp_write && sslpm_hit(r.dp_addr, `SSLPM_OFS_LOW_CTL);
    assign wr_high = r.dp_write &&
        sslpm_hit(r.dp_addr, `SSLPM_OFS_HIGH_CTL);
    assign wr_status = r.dp_write &&
        sslpm_hit(r.dp_addr, `SSLPM_OFS_STATUS);
    assign wr_ctl = sslpm_ctl_t'(HWDATA[`SSLPM_CTL_W-1:0]);

    // --------
    // Configuration hazard check
    // --------
    assign low_fast = !r.low_ctl.supervisor_enable ||
        r.low_ctl.supervisor_full_perf ||
        !r.low_ctl.monitor_enable ||
        r.low_ctl.monitor_full_perf; // RULE1
    assign high_sup_risk = r.high_ctl.supervisor_enable &&
        !r.high_ctl.supervisor_full_perf &&
        (!r.high_ctl.supervisor_keep_in_sleep ||
        r.high_ctl.side_auto_control); // RULE9
    assign high_mon_risk = r.high_ctl.monitor_enable &&
        !r.high_ctl.monitor_full_perf &&
        r.high_ctl.side_auto_control; // RULE10

    // --------
    // Settle and wake timers
    // --------
    // A side written with supervisor_full_perf set settles fast; otherwise the long
    // delay applies, which is what keeps a core-level raise safe.
    assign low_load = wr_ctl.supervisor_full_perf ?
        SETTLE_FAST_CYC : SETTLE_SLOW_CYCLES;
    assign high_load = wr_ctl.supervisor_full_perf ?
        SETTLE_FAST_CYC : SETTLE_SLOW_CYCLES;
    assign settling = low_busy || high_busy;
    assign deep = (r.mode == SSLPM_DEEP_SLEEP) ||
        (r.mode == SSLPM_WAKING);
    assign wake_start = (r.mode == SSLPM_DEEP_SLEEP) && WAKE_IRQ;
    assign wake_load = (r.low_ctl.supervisor_enable &&
        !r.low_ctl.supervisor_full_perf) ?
        WAKE_SLOW_CYCLES : WAKE_FAST_CYC; // RULE5
    assign deep_enter = (r.mode == SSLPM_ACTIVE_RUN_STATE) &&
        !settling && !WAKE_IRQ &&
        (r.deep_pend || (SLEEP_REQ && sslpm_is_deep(SLEEP_LEVEL)));
    assign risk_hit = haz_busy && WAKE_IRQ && r.hazard; // RULE16

    sslpm_timer u_low_settle (
        .clk(CORE_CLK),
        .rst(SYS_RST),
        .start(wr_low),
        .load(low_load),
        .busy(low_busy),
        .done()
    );

    sslpm_timer u_high_settle (
        .clk(CORE_CLK),
        .rst(SYS_RST),
        .start(wr_high),
        .load(high_load),
        .busy(high_busy),
        .done()
    );

    // Window after deep entry in which an interrupt is at risk
    sslpm_timer u_hazard_win (
        .clk(CORE_CLK),
        .rst(SYS_RST),
        .start(deep_enter),
        .load(HAZARD_WIN_CYC),
        .busy(haz_busy),
        .done()
    );

    sslpm_timer u_wake (
        .clk(CORE_CLK),
        .rst(SYS_RST),
        .start(wake_start),
        .load(wake_load),
        .busy(),
        .done(wake_fire)
    );

    // --------
    // State mapping
    // --------
    sslpm_state_map u_low_map (
        .ctl(r.low_ctl),
        .deep(deep),
        .side(low_map)
    );

    sslpm_state_map u_high_map (
        .ctl(r.high_ctl),
        .deep(deep),
        .side(high_map)
    );

    // --------
    // Status word
    // --------
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`SSLPM_ST_LOW_SETTLE] = low_busy;
        status_word[`SSLPM_ST_HIGH_SETTLE] = high_busy;
        status_word[`SSLPM_ST_HAZARD] = r.hazard;
        status_word[`SSLPM_ST_WAKE_RISK] = r.wake_risk;
        status_word[`SSLPM_ST_MODE_LSB +: 2] = r.mode;
        status_word[`SSLPM_ST_LOW_LSB +: 4] = r.low_state;
        status_word[`SSLPM_ST_HIGH_LSB +: 4] = r.high_state;
    end

    // --------
    // Next state
    // --------
    always_comb begin
        next_r = r;
        next_r.readyout = 1'b1;
        next_r.resp = 1'b0;
        next_r.sleep_ack = 1'b0;
        next_r.wake_done = 1'b0;

        // Address phase captured, read data prepared for data phase
        next_r.dp_write = addr_take && HWRITE;
        next_r.dp_addr = {HADDR[7:2], 2'b00};
        next_r.rdata = 32'h0000_0000;
        if (addr_take && !HWRITE) begin
            if (sslpm_hit(HADDR[7:0], `SSLPM_OFS_LOW_CTL)) begin
                next_r.rdata[`SSLPM_CTL_W-1:0] = r.low_ctl;
            end else if (sslpm_hit(HADDR[7:0],
                `SSLPM_OFS_HIGH_CTL)) begin
                next_r.rdata[`SSLPM_CTL_W-1:0] = r.high_ctl;
            end else if (sslpm_hit(HADDR[7:0], `SSLPM_OFS_STATUS)) begin
                next_r.rdata = status_word;
            end
        end

        // Data phase writes
        if (wr_low) begin
            next_r.low_ctl = wr_ctl;
        end
        if (wr_high) begin
            next_r.high_ctl = wr_ctl;
        end
        // Write one clears; a new hit in the same cycle wins
        if (wr_status && HWDATA[`SSLPM_ST_WAKE_RISK]) begin
            next_r.wake_risk = 1'b0;
        end
        if (risk_hit) begin
            next_r.wake_risk = 1'b1;
        end

        next_r.hazard = low_fast &&
            (high_sup_risk || high_mon_risk); // RULE2 RULE7 RULE8
        next_r.low_state = low_map;
        next_r.high_state = high_map;

        // Power mode sequencing
        unique case (r.mode)
            SSLPM_ACTIVE_RUN_STATE: begin
                if (deep_enter) begin
                    // Deep entry held off while either side settles
                    next_r.mode = SSLPM_DEEP_SLEEP;
                    next_r.deep_pend = 1'b0;
                    next_r.sleep_ack = 1'b1;
                end else if (WAKE_IRQ) begin
                    next_r.deep_pend = 1'b0;
                end else if (SLEEP_REQ) begin
                    if (sslpm_is_deep(SLEEP_LEVEL)) begin
                        next_r.deep_pend = 1'b1;
                    end else begin
                        next_r.mode = SSLPM_LIGHT_SLEEP;
                        next_r.sleep_ack = 1'b1;
                    end
                end
            end
            SSLPM_LIGHT_SLEEP: begin
                if (WAKE_IRQ) begin
                    next_r.mode = SSLPM_ACTIVE_RUN_STATE;
                    next_r.wake_done = 1'b1;
                end
            end
            SSLPM_DEEP_SLEEP: begin
                if (WAKE_IRQ) begin
                    next_r.mode = SSLPM_WAKING;
                end
            end
            SSLPM_WAKING: begin
                if (wake_fire) begin
                    next_r.mode = SSLPM_ACTIVE_RUN_STATE;
                    next_r.wake_done = 1'b1; // RULE5
                end
            end
        endcase
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            r <= '0;
            r.readyout <= 1'b1;
            r.low_ctl <= `SSLPM_LOW_CTL_RST;
            r.high_ctl <= `SSLPM_HIGH_CTL_RST;
        end else begin
            r <= next_r;
        end
    end

    // --------
    // Outputs
    // --------
    assign HRDATA = r.rdata;
    assign HREADYOUT = r.readyout;
    assign HRESP = r.resp;
    assign POWER_MODE = r.mode;
    assign SLEEP_ACK = r.sleep_ack;
    assign WAKE_DONE = r.wake_done;
    assign LOW_STATE = r.low_state;
    assign HIGH_STATE = r.high_state;
    assign CONFIG_HAZARD = r.hazard;
    assign LOW_SETTLE = low_busy;
    assign HIGH_SETTLE = high_busy;
    assign WAKE_RISK = r.wake_risk;

endmodule // sslpm_top

// [common/sslpm_consts.svh]
`ifndef SSLPM_CONSTS_SVH
`define SSLPM_CONSTS_SVH

// --------
// Register byte offsets, low eight address bits
// --------
`define SSLPM_OFS_LOW_CTL 8'h00
`define SSLPM_OFS_HIGH_CTL 8'h04
`define SSLPM_OFS_STATUS 8'h08

// --------
// Control register fields, both sides
// --------
`define SSLPM_CTL_W 6
`define SSLPM_LOW_CTL_RST 6'h00
`define SSLPM_HIGH_CTL_RST 6'h00

// --------
// Status register fields
// --------
`define SSLPM_ST_LOW_SETTLE 0
`define SSLPM_ST_HIGH_SETTLE 1
`define SSLPM_ST_HAZARD 2
`define SSLPM_ST_WAKE_RISK 3
`define SSLPM_ST_MODE_LSB 4
`define SSLPM_ST_LOW_LSB 6
`define SSLPM_ST_HIGH_LSB 10

// --------
// Bus encodings
// --------
`define SSLPM_HSIZE_WORD 3'h2

// --------
// Timing
// --------
`define SSLPM_CLK_MHZ 100
`define SSLPM_SETTLE_FAST_NS 2000
`define SSLPM_SLOW_US 150
`define SSLPM_HAZARD_WIN_US 1
`define SSLPM_WAKE_FAST_NS 10
`define SSLPM_SETTLE_FAST_CYC \
    ((`SSLPM_SETTLE_FAST_NS * `SSLPM_CLK_MHZ + 999) / 1000)
`define SSLPM_HAZARD_WIN_CYC (`SSLPM_HAZARD_WIN_US * `SSLPM_CLK_MHZ)
`define SSLPM_WAKE_FAST_CYC \
    ((`SSLPM_WAKE_FAST_NS * `SSLPM_CLK_MHZ + 999) / 1000)
`define SSLPM_SLOW_CYC (`SSLPM_SLOW_US * `SSLPM_CLK_MHZ)

`endif

// [common/sslpm_pkg.sv]
package sslpm_pkg;

    // --------------------------------------------------------
    // Operating state of one supervisor or monitor
    // --------------------------------------------------------
    typedef enum logic [1:0] {
        SSLPM_OFF = 2'b00,
        SSLPM_NORMAL = 2'b01,
        SSLPM_FULL_PERF = 2'b10
    } sslpm_unit_t;

    typedef enum logic [2:0] {
        SSLPM_SLEEP_LEVEL_ZERO = 3'b000,
        SSLPM_SLEEP_LEVEL_ONE = 3'b001,
        SSLPM_SLEEP_LEVEL_TWO = 3'b010,
        SSLPM_SLEEP_LEVEL_THREE = 3'b011,
        SSLPM_SLEEP_LEVEL_FOUR = 3'b100
    } sslpm_level_t;

    typedef enum logic [1:0] {
        SSLPM_ACTIVE_RUN_STATE = 2'b00,
        SSLPM_LIGHT_SLEEP = 2'b01,
        SSLPM_DEEP_SLEEP = 2'b10,
        SSLPM_WAKING = 2'b11
    } sslpm_mode_t;

    // Bit 0 is supervisor_enable, bit 5 side_auto_control
    typedef struct packed {
        logic side_auto_control;
        logic monitor_full_perf;
        logic monitor_enable;
        logic supervisor_full_perf;
        logic supervisor_keep_in_sleep;
        logic supervisor_enable;
    } sslpm_ctl_t;

    typedef struct packed {
        sslpm_unit_t monitor;
        sslpm_unit_t supervisor;
    } sslpm_side_t;

    typedef struct packed {
        sslpm_ctl_t low_ctl;
        sslpm_ctl_t high_ctl;
        logic dp_write;
        logic [7:0] dp_addr;
        logic [31:0] rdata;
        logic readyout;
        logic resp;
        sslpm_mode_t mode;
        logic deep_pend;
        logic sleep_ack;
        logic wake_done;
        sslpm_side_t low_state;
        sslpm_side_t high_state;
        logic hazard;
        logic wake_risk;
    } sslpm_top_state_t;

    typedef struct packed {
        logic [15:0] count;
        logic busy;
        logic done;
    } sslpm_timer_state_t;

    // --------------------------------------------------------
    // Shared decoding
    // --------------------------------------------------------
    function automatic sslpm_unit_t sslpm_unit_state(
        input logic en,
        input logic keep,
        input logic fp,
        input logic auto_ctl,
        input logic deep
    );
        sslpm_unit_t run;
        run = fp ? SSLPM_FULL_PERF : SSLPM_NORMAL;
        if (!en) begin
            return SSLPM_OFF;
        end else if (!deep) begin
            return run;
        end else if (auto_ctl) begin
            return (keep && fp) ? SSLPM_NORMAL : SSLPM_OFF;
        end
        return keep ? run : SSLPM_OFF;
    endfunction

    function automatic logic sslpm_is_deep(input sslpm_level_t lvl);
        return lvl >= SSLPM_SLEEP_LEVEL_TWO;
    endfunction

endpackage

// [core/sslpm_state_map.sv]
`timescale 1ns/1ns
module sslpm_state_map
    import sslpm_pkg::*;
(
    input sslpm_pkg::sslpm_ctl_t ctl,
    input logic deep,
    output sslpm_pkg::sslpm_side_t side
);

    always_comb begin
        // RULE12 RULE13 RULE14 RULE15
        side.supervisor = sslpm_unit_state(ctl.supervisor_enable,
            ctl.supervisor_keep_in_sleep, ctl.supervisor_full_perf,
            ctl.side_auto_control, deep);
        // Monitors have no keep bit and always hold in manual mode
        side.monitor = sslpm_unit_state(ctl.monitor_enable, 1'b1,
            ctl.monitor_full_perf, ctl.side_auto_control, deep); // RULE15
    end

endmodule // sslpm_state_map

// [core/sslpm_timer.sv]
`timescale 1ns/1ns
module sslpm_timer
    import sslpm_pkg::*;
(
    input logic clk,
    input logic rst,
    input logic start,
    input logic [15:0] load,
    output logic busy,
    output logic done
);

    sslpm_timer_state_t r;
    sslpm_timer_state_t next_r;

    // A start while busy restarts the full interval
    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        if (start) begin
            next_r.count = load;
            next_r.busy = 1'b1;
        end else if (r.busy) begin
            if (r.count <= 16'h0001) begin
                next_r.count = 16'h0000;
                next_r.busy = 1'b0;
                next_r.done = 1'b1;
            end else begin
                next_r.count = r.count - 16'h0001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign busy = r.busy;
    assign done = r.done;

endmodule // sslpm_timer

// [tb/sslpm_asserts.sv]
`timescale 1ns/1ns
`include "sslpm_consts.svh"
module sslpm_asserts
    import sslpm_pkg::*;
#(
    parameter logic [15:0] WAKE_SLOW_CYCLES = 16'h3A98
)
(
    input logic CORE_CLK,
    input logic SYS_RST,
    input logic HSEL,
    input logic [31:0] HADDR,
    input logic [1:0] HTRANS,
    input logic HWRITE,
    input logic [2:0] HSIZE,
    input logic SLEEP_REQ,
    input sslpm_pkg::sslpm_level_t SLEEP_LEVEL,
    input logic WAKE_IRQ,
    input sslpm_pkg::sslpm_mode_t POWER_MODE,
    input logic SLEEP_ACK,
    input logic WAKE_DONE,
    input sslpm_pkg::sslpm_side_t LOW_STATE,
    input sslpm_pkg::sslpm_side_t HIGH_STATE,
    input logic CONFIG_HAZARD,
    input logic LOW_SETTLE,
    input logic HIGH_SETTLE,
    input logic WAKE_RISK
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);
    wire act = POWER_MODE == SSLPM_ACTIVE_RUN_STATE;
    wire deep = POWER_MODE == SSLPM_DEEP_SLEEP;
    logic slow;
    logic [15:0] wcnt;
    logic [7:0] dcnt;
    // --------
    // Wake span and entry window counters
    // --------
    // Slow wake is judged from the last awake view of the low supervisor
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            slow <= 1'b0;
            wcnt <= 16'h0000;
            dcnt <= 8'h00;
        end else begin
            if (act) begin
                slow <= LOW_STATE.supervisor == SSLPM_NORMAL;
            end
            if (deep) begin
                wcnt <= 16'h0000;
                dcnt <= (dcnt == 8'hFF) ? dcnt : dcnt + 8'h01;
            end else begin
                dcnt <= 8'h00;
                if (POWER_MODE == SSLPM_WAKING) begin
                    wcnt <= wcnt + 16'h0001;
                end
            end
        end
    end
    a_low_gate: assert property (act && $past(act) &&
        $stable(LOW_STATE) && LOW_STATE == {SSLPM_NORMAL, SSLPM_NORMAL}
        |-> !CONFIG_HAZARD) else $error("hazard with slow low side");
    a_high_gate: assert property (act && $past(act) &&
        $stable(HIGH_STATE) && HIGH_STATE.supervisor != SSLPM_NORMAL &&
        HIGH_STATE.monitor != SSLPM_NORMAL |-> !CONFIG_HAZARD)
        else $error("hazard without a normal high unit");
    a_low_deep_cap: assert property (act ##1 deep |=>
        LOW_STATE.supervisor <= $past(LOW_STATE.supervisor, 2) &&
        LOW_STATE.monitor <= $past(LOW_STATE.monitor, 2))
        else $error("low unit rose on deep entry");
    a_high_deep_cap: assert property (act ##1 deep |=>
        HIGH_STATE.supervisor <= $past(HIGH_STATE.supervisor, 2) &&
        HIGH_STATE.monitor <= $past(HIGH_STATE.monitor, 2))
        else $error("high unit rose on deep entry");
    a_wake_time: assert property ($fell(POWER_MODE == SSLPM_WAKING)
        |-> WAKE_DONE &&
        wcnt == (slow ? WAKE_SLOW_CYCLES + 16'h0001 : 16'h0002))
        else $error("wake span wrong");
    a_deep_gated: assert property (act ##1 deep
        |-> $past(!LOW_SETTLE && !HIGH_SETTLE) && SLEEP_ACK)
        else $error("deep entry while settling");
    a_light_ack: assert property (SLEEP_REQ && act &&
        SLEEP_LEVEL <= SSLPM_SLEEP_LEVEL_ONE
        |=> SLEEP_ACK && POWER_MODE == SSLPM_LIGHT_SLEEP)
        else $error("light entry missing");
    a_risk_set: assert property (deep && dcnt < 8'd90 &&
        WAKE_IRQ && CONFIG_HAZARD |=> WAKE_RISK)
        else $error("early interrupt not flagged");
    a_risk_cause: assert property ($rose(WAKE_RISK) |->
        $past(WAKE_IRQ && CONFIG_HAZARD && deep))
        else $error("risk flag without cause");
    a_settle_cause: assert property ($rose(HIGH_SETTLE) |->
        $past(HSEL && HTRANS[1] && HWRITE && HSIZE == `SSLPM_HSIZE_WORD
        && HADDR[7:0] == `SSLPM_OFS_HIGH_CTL, 2))
        else $error("high settle without write");
    c_deep: cover property (act ##1 deep);
    c_risk: cover property ($rose(WAKE_RISK));
    c_slow: cover property ($fell(POWER_MODE == SSLPM_WAKING) && slow);
endmodule // sslpm_asserts

// [tb/sslpm_cpu_model.sv]
`timescale 1ns/1ns
module sslpm_cpu_model
    import sslpm_pkg::*;
(
    input logic clk,
    input logic rst,
    input logic go,
    input logic wait_settle,
    input sslpm_pkg::sslpm_level_t lvl,
    input logic irq,
    input logic low_settle,
    input logic high_settle,
    output logic sleep_req,
    output sslpm_pkg::sslpm_level_t sleep_level,
    output logic wake_irq
);
    logic pend;
    wire busy = wait_settle && (low_settle || high_settle);
    always_ff @(posedge clk) begin
        sleep_level <= lvl;
        wake_irq <= irq;
        if (rst) begin
            pend <= 1'b0;
            sleep_req <= 1'b0;
        end else begin
            // Careful software holds its request until both sides settle
            sleep_req <= (go || pend) && !busy;
            pend <= (go || pend) && busy;
        end
    end
endmodule // sslpm_cpu_model

// [tb/sslpm_bench.sv]
`timescale 1ns/1ns
`include "sslpm_consts.svh"
bind sslpm_top sslpm_asserts #(.WAKE_SLOW_CYCLES(WAKE_SLOW_CYCLES))
    u_chk (.*);
module sslpm_bench;
    import sslpm_pkg::*;
    localparam logic [15:0] SLOW = 16'h0014;
    logic clk, rst, hsel, hwrite, go, wset, irq, hreadyout, hresp;
    logic sleep_req, wake_irq, sleep_ack, wake_done, hazard, wake_risk;
    logic low_settle, high_settle;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    sslpm_level_t lvl, sleep_level;
    sslpm_mode_t power_mode;
    sslpm_side_t low_state, high_state;
    int n_fail = 0;
    int compares = 0;
    sslpm_top #(.SETTLE_SLOW_CYCLES(SLOW), .WAKE_SLOW_CYCLES(SLOW)) uut (
        .CORE_CLK(clk), .SYS_RST(rst), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
        .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
        .HRESP(hresp), .SLEEP_REQ(sleep_req), .SLEEP_LEVEL(sleep_level),
        .WAKE_IRQ(wake_irq), .POWER_MODE(power_mode), .SLEEP_ACK(sleep_ack),
        .WAKE_DONE(wake_done), .LOW_STATE(low_state),
        .HIGH_STATE(high_state), .CONFIG_HAZARD(hazard),
        .LOW_SETTLE(low_settle), .HIGH_SETTLE(high_settle),
        .WAKE_RISK(wake_risk));
    sslpm_cpu_model cpu (.clk(clk), .rst(rst), .go(go), .wait_settle(wset),
        .lvl(lvl), .irq(irq), .low_settle(low_settle),
        .high_settle(high_settle), .sleep_req(sleep_req),
        .sleep_level(sleep_level), .wake_irq(wake_irq));
    // --------
    // Reference model and bus helpers
    // --------
    function automatic logic [1:0] ust(input logic en, kp, fp, au, dp);
        return !en ? 2'h0 : !dp ? (fp ? 2'h2 : 2'h1) :
            au ? {1'b0, kp & fp} : !kp ? 2'h0 : fp ? 2'h2 : 2'h1;
    endfunction
    // Monitors have no keep bit, so they hold their awake state manually
    function automatic logic [3:0] side(input logic [5:0] c, input logic dp);
        return {ust(c[3], 1'b1, c[4], c[5], dp),
            ust(c[0], c[1], c[2], c[5], dp)};
    endfunction
    function automatic logic hz(input logic [5:0] l, h);
        return (!l[0] | l[2] | !l[3] | l[4]) &
            ((h[0] & !h[2] & (!h[1] | h[5])) |
            (h[3] & !h[4] & h[5]));
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= `SSLPM_HSIZE_WORD;
        haddr <= {24'h0, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do begin
            #1 r = hrdata;
            @(posedge clk);
        end while (hreadyout !== 1'b1);
    endtask
    // Outputs are read once they have settled after the edge
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    // --------
    // Scenarios
    // --------
    task automatic t_reset();
        logic [31:0] r;
        chk("reset ports", {hresp, hreadyout, power_mode, hazard}, 32'h08);
        for (int a = 0; a < 16; a += 4) begin
            bus(1'b0, 8'(a), 32'h0, r);
            chk("reset read", r, 32'h0);
        end
        bus(1'b1, 8'h0C, 32'hFFFFFFFF, r);
        bus(1'b0, 8'h0C, 32'h0, r);
        chk("unmapped read", r, 32'h0);
        bus(1'b0, 8'h00, 32'h0, r);
        chk("unmapped alias", r, 32'h0);
    endtask
    task automatic t_hazard();
        logic [31:0] r;
        for (int h = 0; h < 64; h++) begin
            bus(1'b1, 8'h04, 32'(h), r);
            for (int l = 0; l < 64; l++) begin
                bus(1'b1, 8'h00, 32'(l), r);
                @(posedge clk);
                bus(1'b0, 8'h08, 32'h0, r);
                chk("hazard", hazard, hz(6'(l), 6'(h)));
                chk("status", r & 32'hFFFFFFFC, {18'h0, side(6'(h), 1'b0),
                    side(6'(l), 1'b0), 3'h0, hz(6'(l), 6'(h)), 2'h0});
                chk("low awake", low_state, side(6'(l), 1'b0));
                chk("high awake", high_state, side(6'(h), 1'b0));
            end
        end
    endtask
    task automatic t_settle();
        logic [31:0] r;
        int k;
        bus(1'b1, 8'h00, 32'h04, r);
        k = 0;
        do begin
            tick();
            k++;
        end while (low_settle === 1'b1 && k < 300);
        chk("fast settle", k, `SSLPM_SETTLE_FAST_CYC);
        bus(1'b1, 8'h04, 32'h00, r);
        k = 0;
        do begin
            tick();
            k++;
        end while (high_settle === 1'b1 && k < 300);
        chk("slow settle", k, SLOW);
    endtask
    task automatic sleep_cycle(input logic [2:0] lv, input logic [5:0] lo, hi,
        input logic ws);
        logic [31:0] r;
        logic dp;
        int k;
        int nw;
        dp = lv >= 3'h2;
        bus(1'b1, 8'h00, {26'h0, lo}, r);
        bus(1'b1, 8'h04, {26'h0, hi}, r);
        lvl <= sslpm_level_t'(lv);
        wset <= ws;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        k = 0;
        while (sleep_ack !== 1'b1 && k < 500) begin
            tick();
            k++;
        end
        chk("entry mode", power_mode,
            dp ? SSLPM_DEEP_SLEEP : SSLPM_LIGHT_SLEEP);
        chk("entry settled", {low_settle, high_settle} & {2{dp}}, 0);
        tick();
        chk("sleep low", low_state, side(lo, dp));
        chk("sleep high", high_state, side(hi, dp));
        irq <= 1'b1;
        tick();
        irq <= 1'b0;
        nw = 0;
        k = 0;
        while (wake_done !== 1'b1 && k < 500) begin
            tick();
            k++;
            nw += (power_mode === SSLPM_WAKING);
        end
        chk("wake span", nw, !dp ? 0 : (lo[0] & !lo[2]) ? SLOW + 1 : 2);
        chk("wake risk", wake_risk, dp & hz(lo, hi));
        bus(1'b1, 8'h08, 32'h08, r);
        bus(1'b0, 8'h08, 32'h0, r);
        chk("risk cleared", r[3], 1'b0);
    endtask
    task automatic t_levels();
        sleep_cycle(3'h0, 6'h05, 6'h01, 1'b0);
        sleep_cycle(3'h1, 6'h00, 6'h09, 1'b1);
        sleep_cycle(3'h2, 6'h07, 6'h01, 1'b0);
        sleep_cycle(3'h3, 6'h3F, 6'h2B, 1'b1);
        sleep_cycle(3'h4, 6'h09, 6'h01, 1'b0);
        sleep_cycle(3'h4, 6'h03, 6'h21, 1'b1);
        sleep_cycle(3'h3, 6'h05, 6'h1B, 1'b1);
    endtask
    task automatic close_out();
        if (n_fail == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        close_out();
    end
    initial begin
        rst = 1'b1;
        {hsel, hwrite, go, wset, irq} = 5'h00;
        {haddr, hwdata} = 64'h0;
        {htrans, hsize} = 5'h00;
        lvl = SSLPM_SLEEP_LEVEL_ZERO;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_hazard();
        t_settle();
        t_levels();
        close_out();
    end
endmodule // sslpm_bench
